/* design/jtag_tap_chain_ident.sv */
`default_nettype none
module jtag_tap_chain_ident
  import tap_pkg::*;
#(
  parameter int TILES     = 2,
  parameter int PIN_COUNT = 8
)
(
  input  wire logic                                 clk,
  input  wire logic                                 resetn,
  input  wire logic                                 global_reset_n,
  input  wire logic                                 tck,
  input  wire logic                                 tms,
  input  wire logic                                 tdi,
  output logic                                      tdo,
  output logic                                      tdo_oe,
  input  wire logic                                 pll_locked,
  input  wire logic                                 fuse_loaded,
  input  wire logic [TILES-1:0][31:0]               fuse_security_word,
  input  wire logic [TILES-1:0][PIN_COUNT-1:0]      pin_in,
  output logic      [TILES-1:0][PIN_COUNT-1:0]      pin_out,
  output logic      [TILES-1:0]                     pin_test_mode,
  input  wire logic [TILES-1:0][31:0]               debug_read_word,
  output logic      [TILES-1:0]                     debug_write_valid,
  output logic      [TILES-1:0][31:0]               debug_write_word,
  input  wire logic [TILES-1:0][31:0]               fuse_read_word,
  output logic      [TILES-1:0]                     fuse_write_valid,
  output logic      [TILES-1:0][31:0]               fuse_write_word,
  output logic      [TILES-1:0]                     scan_blocked,
  output logic                                      boot_start,
  output logic      [TILES-1:0]                     boot_from_fuse
);

  localparam int TAPS = 2 * TILES;
  localparam int DR_W = (PIN_COUNT > 32) ? PIN_COUNT : 32;

  if (TILES < 1 || PIN_COUNT < 1)
  begin : bad_params
    $error("TILES and PIN_COUNT must be at least one");
  end

  typedef struct packed {
    logic [IR_WIDTH-1:0]  ir_shift;
    logic [IR_WIDTH-1:0]  ir;
    logic [DR_W-1:0]      dr;
    logic [PIN_COUNT-1:0] pin_hold;
    logic                 tdo;
    logic                 tdo_on;
  } tap_reg_type;

  typedef struct packed {
    logic [1:0]                     rst_sync;
    logic [2:0]                     tck_s;
    logic [1:0]                     tms_s;
    logic [1:0]                     tdi_s;
    logic [1:0]                     lock_s;
    logic [TILES-1:0][PIN_COUNT-1:0] pin_meta;
    logic [TILES-1:0][PIN_COUNT-1:0] pin_sync;
    boot_state_type                 boot;
    logic                           boot_start;
    logic [TILES-1:0]               boot_fuse;
    logic [TILES-1:0]               dbg_valid;
    logic [TILES-1:0][31:0]         dbg_word;
    logic [TILES-1:0]               fuse_valid;
    logic [TILES-1:0][31:0]         fuse_word;
    tap_reg_type [TAPS-1:0]         tap;
  } state_type;

  localparam tap_reg_type TAP_RST = '{ir: OP_DEVICE_IDENTIFICATION_WORD, default: '0};
  localparam state_type   RST_S   = '{tap: {TAPS{TAP_RST}}, boot: BOOT_WAIT, default: '0};

  state_type                  s;
  state_type                  next_s;
  tap_state_type [TAPS-1:0]   tstate;
  logic          [TAPS-1:0]   chain_in;
  logic                       tck_rise;
  logic                       tck_fall;
  logic          [TILES-1:0]  fuse_blocked;
  logic          [31:0]       user_code;

  ////////////////////////////////////////////////////////////////////////////
  // Test clock edges seen from the second sync stage on
  assign tck_rise = s.tck_s[1] & ~s.tck_s[2];
  assign tck_fall = ~s.tck_s[1] & s.tck_s[2];

  // Access locks per tile; debug and fuse access are refused before fuses load
  always_comb
  begin
    for (int t = 0; t < TILES; t++)
    begin
      scan_blocked[t] = ~fuse_loaded | fuse_security_word[t][SEC_SCAN_OFF];
      fuse_blocked[t] = scan_blocked[t] | fuse_security_word[t][SEC_FUSE_LOCK];
    end
  end

  // User code from tile 0's security word, user field zero until fuses load
  assign user_code = {fuse_loaded ? fuse_security_word[0][31:SEC_USER_POS]
                                  : {UC_USER_WIDTH{1'b0}},
                      {(UC_USER_POS - 16){1'b0}}, UC_REVISION};

  ////////////////////////////////////////////////////////////////////////////
  // One state machine per port, chained tile by tile
  for (genvar k = 0; k < TAPS; k++)
  begin : chain
    tap_state_machine u_fsm (
      .clk      (clk),
      .resetn   (resetn & s.rst_sync[1]),
      .areset_n (global_reset_n),
      .step     (tck_rise),
      .tms      (s.tms_s[1]),
      .state    (tstate[k])
    );
    if (k == 0)
    begin : first
      assign chain_in[k] = s.tdi_s[1];
    end
    else
    begin : later
      assign chain_in[k] = s.tap[k-1].tdo;
    end
  end

  // Instruction decode; refused opcodes fall back to bypass
  function automatic logic [IR_WIDTH-1:0] decode_ir(input logic [IR_WIDTH-1:0] op,
                                                     input logic chip,
                                                     input logic scan_off,
                                                     input logic fuse_off);
    logic ok;
    ok = 1'b0;
    case (op)
      OP_DEVICE_IDENTIFICATION_WORD:             ok = 1'b1;
      OP_USERCODE:           ok = chip;
      OP_EXTEST, OP_SAMPLE:  ok = ~chip;
      OP_DEBUG:              ok = chip & ~scan_off;
      OP_FUSE:               ok = chip & ~fuse_off;
      default:               ok = 1'b0;
    endcase
    decode_ir = ok ? op : OP_BYPASS;
  endfunction : decode_ir

  // Data register length per instruction
  function automatic int dr_len(input logic [IR_WIDTH-1:0] op);
    int n;
    n = 32;
    case (op)
      OP_EXTEST, OP_SAMPLE: n = PIN_COUNT;
      OP_DEVICE_IDENTIFICATION_WORD, OP_USERCODE, OP_DEBUG, OP_FUSE: n = 32;
      default:              n = 1;
    endcase
    dr_len = n;
  endfunction : dr_len

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block
  always_comb
  begin
    int  t;
    int  len;
    logic chip;
    t = 0;
    len = 1;
    chip = 1'b0;
    next_s = s;
    next_s.tck_s = {s.tck_s[1:0], tck};
    next_s.tms_s = {s.tms_s[0], tms};
    next_s.tdi_s = {s.tdi_s[0], tdi};
    next_s.lock_s = {s.lock_s[0], pll_locked};
    next_s.pin_meta = pin_in;
    next_s.pin_sync = s.pin_meta;
    next_s.boot_start = 1'b0;
    next_s.dbg_valid = '0;
    next_s.fuse_valid = '0;

    // Boot waits for fuses and a settled PLL lock
    case (s.boot)
      BOOT_WAIT:
      begin
        if (s.lock_s[1] && fuse_loaded)
        begin
          next_s.boot = BOOT_RUN;
          next_s.boot_start = 1'b1;
          for (int b = 0; b < TILES; b++)
          begin
            next_s.boot_fuse[b] = fuse_security_word[b][SEC_FUSE_BOOT];
          end
        end
      end
      BOOT_RUN:
      begin
        next_s.boot = BOOT_RUN;
      end
      default:
      begin
        next_s.boot = BOOT_WAIT;
      end
    endcase

    // Per port: capture, shift and update on test-clock edges
    for (int k = 0; k < TAPS; k++)
    begin
      t = k / 2;
      chip = (k % 2) == 1;
      len = dr_len(s.tap[k].ir);
      if (tck_rise)
      begin
        case (tstate[k])
          TEST_LOGIC_RESET:
          begin
            next_s.tap[k].ir = OP_DEVICE_IDENTIFICATION_WORD;
          end
          CAPTURE_IR:
          begin
            next_s.tap[k].ir_shift = IR_CAPTURE;
          end
          SHIFT_IR:
          begin
            next_s.tap[k].ir_shift = {chain_in[k], s.tap[k].ir_shift[IR_WIDTH-1:1]};
          end
          UPDATE_IR:
          begin
            next_s.tap[k].ir = decode_ir(s.tap[k].ir_shift, chip,
                                         scan_blocked[t], fuse_blocked[t]);
          end
          CAPTURE_DR:
          begin
            next_s.tap[k].dr = '0;
            case (s.tap[k].ir)
              OP_DEVICE_IDENTIFICATION_WORD:
              begin
                next_s.tap[k].dr[31:0] = (32'(ID_VERSION) << ID_VERSION_POS)
                  | (32'(chip ? ID_PART_CHIP : ID_PART_BOUND) << ID_PART_POS)
                  | (32'(ID_MAKER) << ID_MAKER_POS) | 32'h0000_0001;
              end
              OP_USERCODE: next_s.tap[k].dr[31:0] = user_code;
              OP_EXTEST, OP_SAMPLE: next_s.tap[k].dr[PIN_COUNT-1:0] = s.pin_sync[t];
              OP_DEBUG: next_s.tap[k].dr[31:0] = debug_read_word[t];
              OP_FUSE:  next_s.tap[k].dr[31:0] = fuse_read_word[t];
              default:  next_s.tap[k].dr = '0;
            endcase
          end
          SHIFT_DR:
          begin
            for (int i = 0; i < DR_W; i++)
            begin
              if (i == len - 1)
              begin
                next_s.tap[k].dr[i] = chain_in[k];
              end
              else if (i < len - 1)
              begin
                next_s.tap[k].dr[i] = s.tap[k].dr[i+1];
              end
              else
              begin
                next_s.tap[k].dr[i] = 1'b0;
              end
            end
          end
          UPDATE_DR:
          begin
            if (!chip && s.tap[k].ir == OP_EXTEST)
            begin
              next_s.tap[k].pin_hold = s.tap[k].dr[PIN_COUNT-1:0];
            end
            if (chip && s.tap[k].ir == OP_DEBUG && !scan_blocked[t])
            begin
              next_s.dbg_valid[t] = 1'b1;
              next_s.dbg_word[t] = s.tap[k].dr[31:0];
            end
            if (chip && s.tap[k].ir == OP_FUSE && !fuse_blocked[t])
            begin
              next_s.fuse_valid[t] = 1'b1;
              next_s.fuse_word[t] = s.tap[k].dr[31:0];
            end
          end
          default:
          begin
            next_s.tap[k].ir = s.tap[k].ir;
          end
        endcase
      end
      // Output bit changes on the falling edge
      if (tck_fall)
      begin
        next_s.tap[k].tdo = (tstate[k] == SHIFT_IR) ? s.tap[k].ir_shift[0] : s.tap[k].dr[0];
        next_s.tap[k].tdo_on = (tstate[k] == SHIFT_IR) || (tstate[k] == SHIFT_DR);
      end
    end

    if (!resetn || !s.rst_sync[1])  // Held while resetn is low and until global reset release passes two flops
    begin
      next_s = RST_S;
    end
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, cleared at once by global reset
  always_ff @(posedge clk or negedge global_reset_n)
  begin
    if (!global_reset_n)
    begin
      s <= RST_S;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign tdo = s.tap[TAPS-1].tdo;
  assign boot_start = s.boot_start;
  assign boot_from_fuse = s.boot_fuse;
  assign debug_write_valid = s.dbg_valid;
  assign debug_write_word = s.dbg_word;
  assign fuse_write_valid = s.fuse_valid;
  assign fuse_write_word = s.fuse_word;

  always_comb
  begin
    tdo_oe = 1'b0;
    for (int k = 0; k < TAPS; k++)
    begin
      tdo_oe = tdo_oe | s.tap[k].tdo_on;
    end
    for (int t = 0; t < TILES; t++)
    begin
      pin_out[t] = s.tap[2*t].pin_hold;
      pin_test_mode[t] = (s.tap[2*t].ir == OP_EXTEST);
    end
  end

endmodule : jtag_tap_chain_ident
`default_nettype wire

/* design/tap_pkg.sv */
`default_nettype none
package tap_pkg;

  // Instruction register
  localparam int          IR_WIDTH        = 4;
  localparam logic [3:0]  OP_EXTEST       = 4'h0;
  localparam logic [3:0]  OP_DEVICE_IDENTIFICATION_WORD       = 4'h1;
  localparam logic [3:0]  OP_USERCODE     = 4'h2;
  localparam logic [3:0]  OP_SAMPLE       = 4'h3;
  localparam logic [3:0]  OP_DEBUG        = 4'h4;
  localparam logic [3:0]  OP_FUSE         = 4'h5;
  localparam logic [3:0]  OP_BYPASS       = 4'hf;
  localparam logic [3:0]  IR_CAPTURE      = 4'h1;

  // Identification word fields; values are arbitrary
  localparam logic [3:0]  ID_VERSION      = 4'h0;
  localparam logic [15:0] ID_PART_BOUND   = 16'h0a51;
  localparam logic [15:0] ID_PART_CHIP    = 16'h0a52;
  localparam logic [10:0] ID_MAKER        = 11'h2a5;
  localparam int          ID_VERSION_POS  = 28;
  localparam int          ID_PART_POS     = 12;
  localparam int          ID_MAKER_POS    = 1;

  // User-code word fields; revision value is arbitrary
  localparam int          UC_USER_POS     = 22;
  localparam int          UC_USER_WIDTH   = 10;
  localparam logic [15:0] UC_REVISION     = 16'h0001;

  // Security word bits
  localparam int          SEC_SCAN_OFF    = 0;
  localparam int          SEC_FUSE_BOOT   = 5;
  localparam int          SEC_FUSE_LOCK   = 13;
  localparam int          SEC_USER_POS    = 22;

  // External reset hold owed by the reset source
  localparam int          RESET_HOLD_NS   = 100;

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
    PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_type;

  typedef enum logic [0:0] {
    BOOT_WAIT, BOOT_RUN
  } boot_state_type;

endpackage : tap_pkg
`default_nettype wire

/* design/tap_state_machine.sv */
`default_nettype none
module tap_state_machine
  import tap_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    resetn,
  input  wire logic    areset_n,
  input  wire logic    step,
  input  wire logic    tms,
  output tap_state_type state
);

  typedef struct packed {
    tap_state_type st;
  } fsm_type;

  fsm_type s;
  fsm_type next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Standard sixteen-state walk, one step per test-clock rise
  always_comb
  begin
    next_s = s;
    if (step)
    begin
      case (s.st)
        TEST_LOGIC_RESET: next_s.st = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
        RUN_TEST_IDLE:    next_s.st = tms ? SELECT_DR : RUN_TEST_IDLE;
        SELECT_DR:        next_s.st = tms ? SELECT_IR : CAPTURE_DR;
        CAPTURE_DR:       next_s.st = tms ? EXIT1_DR : SHIFT_DR;
        SHIFT_DR:         next_s.st = tms ? EXIT1_DR : SHIFT_DR;
        EXIT1_DR:         next_s.st = tms ? UPDATE_DR : PAUSE_DR;
        PAUSE_DR:         next_s.st = tms ? EXIT2_DR : PAUSE_DR;
        EXIT2_DR:         next_s.st = tms ? UPDATE_DR : SHIFT_DR;
        UPDATE_DR:        next_s.st = tms ? SELECT_DR : RUN_TEST_IDLE;
        SELECT_IR:        next_s.st = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
        CAPTURE_IR:       next_s.st = tms ? EXIT1_IR : SHIFT_IR;
        SHIFT_IR:         next_s.st = tms ? EXIT1_IR : SHIFT_IR;
        EXIT1_IR:         next_s.st = tms ? UPDATE_IR : PAUSE_IR;
        PAUSE_IR:         next_s.st = tms ? EXIT2_IR : PAUSE_IR;
        EXIT2_IR:         next_s.st = tms ? UPDATE_IR : SHIFT_IR;
        UPDATE_IR:        next_s.st = tms ? SELECT_DR : RUN_TEST_IDLE;
        default:          next_s.st = TEST_LOGIC_RESET;
      endcase
    end
    if (!resetn)
    begin
      next_s.st = TEST_LOGIC_RESET;
    end
  end

  // State register, cleared at once by global reset
  always_ff @(posedge clk or negedge areset_n)
  begin
    if (!areset_n)
    begin
      s <= '{st: TEST_LOGIC_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign state = s.st;

endmodule : tap_state_machine
`default_nettype wire

/* bench/jtag_tap_chain_ident_monitor.sv */
`default_nettype none
module jtag_tap_chain_ident_monitor
  import tap_pkg::*;
#(
  parameter int TILES = 2
)
(
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   global_reset_n,
  input wire logic                   tck,
  input wire logic                   tdo_oe,
  input wire logic                   pll_locked,
  input wire logic                   fuse_loaded,
  input wire logic [TILES-1:0][31:0] fuse_security_word,
  input wire logic [TILES-1:0]       pin_test_mode,
  input wire logic [TILES-1:0]       debug_write_valid,
  input wire logic [TILES-1:0]       fuse_write_valid,
  input wire logic [TILES-1:0]       scan_blocked,
  input wire logic                   boot_start,
  input wire logic [TILES-1:0]       boot_from_fuse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [TILES-1:0] blocked_exp;
  logic [TILES-1:0] lock_bits;
  logic [TILES-1:0] boot_bits;
  logic             boot_seen;

  // Expected per-tile gates from the security words
  always_comb
  begin
    for (int t = 0; t < TILES; t++)
    begin
      blocked_exp[t] = !fuse_loaded || fuse_security_word[t][SEC_SCAN_OFF];
      lock_bits[t]   = fuse_security_word[t][SEC_FUSE_LOCK];
      boot_bits[t]   = fuse_security_word[t][SEC_FUSE_BOOT];
    end
  end

  // Remembers a boot start since the last reset
  always_ff @(posedge clk)
  begin
    if (!resetn || !global_reset_n)
      boot_seen <= 1'b0;
    else if (boot_start)
      boot_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_block_level: assert property (scan_blocked == blocked_exp)
    else $error("scan block flag wrong");
  a_boot_lock: assert property (boot_start |-> $past(pll_locked, 3) && $past(fuse_loaded))
    else $error("boot started without lock");
  a_boot_once: assert property (boot_start |-> !boot_seen)
    else $error("second boot start");
  a_boot_source: assert property (boot_start |-> boot_from_fuse == $past(boot_bits))
    else $error("boot source wrong");
  a_write_pulse: assert property ((|debug_write_valid) || (|fuse_write_valid) |=>
    debug_write_valid == '0 && fuse_write_valid == '0)
    else $error("write pulse too long");
  a_write_on_rise: assert property ((|debug_write_valid) || (|fuse_write_valid) |-> tck)
    else $error("write away from link clock high");
  a_debug_gate: assert property (!(|(debug_write_valid & scan_blocked)))
    else $error("debug write while blocked");
  a_fuse_gate: assert property (!(|(fuse_write_valid & (scan_blocked | lock_bits))))
    else $error("fuse write while locked");
  a_reset_quiet: assert property (!global_reset_n |-> !tdo_oe && pin_test_mode == '0 && !boot_start)
    else $error("outputs active in global reset");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
    else $error("shift output enable changed while link clock high");
endmodule : jtag_tap_chain_ident_monitor

bind jtag_tap_chain_ident jtag_tap_chain_ident_monitor #(.TILES(TILES)) u_monitor (
  .clk(clk), .resetn(resetn), .global_reset_n(global_reset_n), .tck(tck), .tdo_oe(tdo_oe),
  .pll_locked(pll_locked), .fuse_loaded(fuse_loaded), .fuse_security_word(fuse_security_word),
  .pin_test_mode(pin_test_mode), .debug_write_valid(debug_write_valid),
  .fuse_write_valid(fuse_write_valid), .scan_blocked(scan_blocked), .boot_start(boot_start),
  .boot_from_fuse(boot_from_fuse));
`default_nettype wire

/* bench/jtag_host_model.sv */
`default_nettype none
module jtag_host_model
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link clock rests low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link clock period; returns the data output seen before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 q = tdo;
    tck = 1'b1;
    #80 tck = 1'b0;
  endtask : step

  // Five clocks with mode select high, then to idle
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : reset5

  // Shift n bits LSB first through instruction or data path, idle to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir)
      step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask : scan
endmodule : jtag_host_model
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
module tb
  import tap_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 global_reset_n = 1'b0;
  logic                 pll_locked = 1'b0;
  logic                 fuse_loaded = 1'b0;
  logic [1:0][31:0]     sec = '0;
  logic [1:0][7:0]      pin_in = '0;
  logic [1:0][31:0]     dbg_rd = '0;
  logic [1:0][31:0]     fuse_rd = '0;
  logic [1:0][7:0]      pin_out;
  logic [1:0]           pin_test_mode;
  logic [1:0]           dbg_wv;
  logic [1:0]           fuse_wv;
  logic [1:0][31:0]     dbg_ww;
  logic [1:0][31:0]     fuse_ww;
  logic [1:0]           boot_from_fuse;
  logic                 tck, tms, tdi, tdo, tdo_oe, boot_start;
  logic [127:0]         din, dout;
  logic [3:0]           op;
  logic                 ok;
  integer               seed = 32'hd840_0a8a;
  int                   bad_count = 0;
  int                   n_tests = 0;
  int                   dw = 0;
  int                   fw = 0;
  int                   wr = 0;
  int                   boot_count = 0;

  always #5 clk = ~clk;

  jtag_tap_chain_ident #(.TILES(2), .PIN_COUNT(8)) u_jtag_tap_chain_ident (
    .clk(clk), .resetn(resetn), .global_reset_n(global_reset_n), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pll_locked(pll_locked), .fuse_loaded(fuse_loaded),
    .fuse_security_word(sec), .pin_in(pin_in), .pin_out(pin_out), .pin_test_mode(pin_test_mode),
    .debug_read_word(dbg_rd), .debug_write_valid(dbg_wv), .debug_write_word(dbg_ww),
    .fuse_read_word(fuse_rd), .fuse_write_valid(fuse_wv), .fuse_write_word(fuse_ww),
    .scan_blocked(), .boot_start(boot_start), .boot_from_fuse(boot_from_fuse));

  jtag_host_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // Counts tile 1 write pulses and boot starts where they are settled
  always @(negedge clk)
  begin
    if (dbg_wv[1] === 1'b1)
      dw++;
    if (fuse_wv[1] === 1'b1)
      fw++;
    if (boot_start === 1'b1)
      boot_count++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic good, input string what);
    n_tests++;
    if (good !== 1'b1)
    begin
      bad_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check

  function automatic logic [31:0] id_exp(input logic chip);
    return {ID_VERSION, chip ? ID_PART_CHIP : ID_PART_BOUND, ID_MAKER, 1'b1};
  endfunction : id_exp

  function automatic logic [31:0] uc_exp();
    return {fuse_loaded ? sec[0][31:22] : 10'h000, 6'h00, UC_REVISION};
  endfunction : uc_exp

  task automatic load_ir(input logic [15:0] ir);
    u_host.scan(1'b1, 16, {112'h0, ir}, dout);
    check(dout[15:0] === 16'h1111, "instruction capture");
  endtask : load_ir

  task automatic id_read();
    u_host.scan(1'b0, 128, '0, dout);
    check(dout === {id_exp(0), id_exp(1), id_exp(0), id_exp(1)}, "id chain");
  endtask : id_read

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hung handshake
  initial
  begin
    #400_000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    global_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    u_host.reset5();
    id_read();
    for (int k = 0; k < 3; k++)
    begin
      fuse_loaded = (k != 0);
      sec[0] = (k == 1) ? 32'h0000_0000 : $random(seed);
      load_ir({OP_USERCODE, OP_USERCODE, OP_USERCODE, OP_USERCODE});
      u_host.scan(1'b0, 66, '0, dout);
      check(dout[65:0] === {1'b0, uc_exp(), 1'b0, uc_exp()}, "user code");
    end
    sec[1] = $random(seed);
    check(boot_count == 0, "boot before lock");
    pll_locked = 1'b1;
    for (int w = 0; w < 20 && boot_count == 0; w++)
      @(negedge clk);
    check(boot_count == 1 && boot_from_fuse === {sec[1][5], sec[0][5]}, "boot");
    for (int k = 0; k < 6; k++)
    begin
      op = (k % 2) ? OP_FUSE : OP_DEBUG;
      sec[1] = $random(seed) & 32'hffff_dffe;
      if (k / 2 == 1)
        sec[1][SEC_SCAN_OFF] = 1'b1;
      if (k / 2 == 2)
        sec[1][SEC_FUSE_LOCK] = 1'b1;
      ok = !sec[1][SEC_SCAN_OFF] && !(op == OP_FUSE && sec[1][SEC_FUSE_LOCK]);
      din = {$random(seed), $random(seed), $random(seed), $random(seed)};
      dbg_rd = {$random(seed), $random(seed)};
      fuse_rd = {$random(seed), $random(seed)};
      wr = (op == OP_FUSE) ? fw : dw;
      load_ir({OP_BYPASS, OP_BYPASS, OP_BYPASS, op});
      u_host.scan(1'b0, 35, din, dout);
      @(negedge clk);
      wr = ((op == OP_FUSE) ? fw : dw) - wr;
      check(ok ? (wr == 1 && dout[31:0] === ((op == OP_FUSE) ? fuse_rd[1] : dbg_rd[1])
        && ((op == OP_FUSE) ? fuse_ww[1] : dbg_ww[1]) === din[31:0])
        : (wr == 0 && dout[0] === 1'b0), "chip port access");
    end
    for (int k = 0; k < 2; k++)
    begin
      op = k ? OP_EXTEST : OP_SAMPLE;
      pin_in = 16'($random(seed));
      din = {$random(seed), $random(seed), $random(seed), $random(seed)};
      load_ir({op, op, op, op});
      u_host.scan(1'b0, 18, din, dout);
      check(dout[17:0] === {pin_in[0], 1'b0, pin_in[1], 1'b0} && pin_test_mode === {2{k[0]}}
        && (k == 0 || pin_out === {din[8:1], din[17:10]}), "boundary scan");
    end
    u_host.reset5();
    check(pin_test_mode === 2'b00, "mode after port reset");
    id_read();
    load_ir({OP_EXTEST, OP_BYPASS, OP_EXTEST, OP_BYPASS});
    @(negedge clk);
    check(pin_test_mode === 2'b11, "boundary mode before reset");
    global_reset_n = 1'b0;
    #1 check(pin_test_mode === 2'b00 && tdo_oe === 1'b0, "asynchronous reset");
    repeat (RESET_HOLD_NS / 10 + 2) @(negedge clk);
    global_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    u_host.reset5();
    id_read();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
